/* File: hw/fieldbus_config_fail_action.sv */
// fieldbus configuration, command routing and network failure supervision
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "fbcfg_cfg.svh"
module fieldbus_config_fail_action (
    input  wire logic        CORE_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic [7:0]  AXI_AWADDR_I,
    input  wire logic        AXI_AWVALID_I,
    output logic             AXI_AWREADY_O,
    input  wire logic [31:0] AXI_WDATA_I,
    input  wire logic [3:0]  AXI_WSTRB_I,
    input  wire logic        AXI_WVALID_I,
    output logic             AXI_WREADY_O,
    output logic [1:0]       AXI_BRESP_O,
    output logic             AXI_BVALID_O,
    input  wire logic        AXI_BREADY_I,
    input  wire logic [7:0]  AXI_ARADDR_I,
    input  wire logic        AXI_ARVALID_I,
    output logic             AXI_ARREADY_O,
    output logic [31:0]      AXI_RDATA_O,
    output logic [1:0]       AXI_RRESP_O,
    output logic             AXI_RVALID_O,
    input  wire logic        AXI_RREADY_I,
    input  wire logic        CONN_INACTIVE_I,
    input  wire logic        BOARD_INACTIVE_I,
    input  wire logic        NET_RUN_I,
    input  wire logic        NET_DIR_I,
    input  wire logic        NET_JOG_I,
    input  wire logic        NET_REMOTE_I,
    input  wire logic [6:0]  NET_DOUT_I,
    input  wire logic        LOC_RUN_I,
    input  wire logic        LOC_DIR_I,
    input  wire logic        LOC_JOG_I,
    input  wire logic        LOC_REMOTE_I,
    input  wire logic [6:0]  LOC_DOUT_I,
    input  wire logic [3:0]  ADDR_TENS_I,
    input  wire logic [3:0]  ADDR_UNITS_I,
    input  wire logic        BUS_RXD_I,
    output logic             RUN_O,
    output logic             DIR_O,
    output logic             JOG_O,
    output logic             REMOTE_O,
    output logic             SPD_REF_NET_O,
    output logic [6:0]       DOUT_O,
    output logic             GEN_ENABLE_O,
    output logic             RAMP_STOP_O,
    output logic             FAULT_O,
    output logic             COMM_ERR_O,
    output logic             CARD_ENABLE_O,
    output logic [2:0]       PROTOCOL_O,
    output logic [2:0]       IO_WORDS_O,
    output logic [6:0]       NODE_ADDR_O,
    output logic [3:0]       BAUD_IDX_O,
    output logic             IRQ_O
);
    typedef struct packed {
        logic       conn;
        logic       board;
        logic       n_run;
        logic       n_dir;
        logic       n_jog;
        logic       n_rem;
        logic [6:0] n_dout;
        logic       l_run;
        logic       l_dir;
        logic       l_jog;
        logic       l_rem;
        logic [6:0] l_dout;
        logic [3:0] tens;
        logic [3:0] units;
        logic       rxd;
    } pins_s;

    typedef struct packed {
        pins_s                  s1;
        pins_s                  s2;
        logic [1:0]             err_prev;
        logic [3:0]             mode;
        logic [3:0]             act;
        logic [8:0]             src;
        logic [6:0]             outfn;
        logic [3:0]             irq_st;
        logic [3:0]             irq_mask;
        fbcfg_pkg::sup_state_e  sup;
        logic                   ramp;
        logic                   gen_dis;
        logic                   force_loc;
        logic [7:0]             last_err;
        logic                   aw_h;
        logic                   w_h;
        logic [7:0]             awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   awrdy;
        logic                   wrdy;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arrdy;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   run;
        logic                   dir;
        logic                   jog;
        logic                   remote;
        logic                   spd_net;
        logic [6:0]             dout;
        logic                   comm_err;
        logic                   bd_restart;
        logic [6:0]             node;
        fbcfg_pkg::mode_s       mdec;
        logic                   irq;
        logic                   fault;
        logic                   gen_en;
        logic                   card_en;
    } st_s;

    st_s     q;
    st_s     d;
    pins_s   pins;
    fbcfg_if bdl ();

    assign pins = '{conn: CONN_INACTIVE_I, board: BOARD_INACTIVE_I,
                    n_run: NET_RUN_I, n_dir: NET_DIR_I, n_jog: NET_JOG_I,
                    n_rem: NET_REMOTE_I, n_dout: NET_DOUT_I,
                    l_run: LOC_RUN_I, l_dir: LOC_DIR_I, l_jog: LOC_JOG_I,
                    l_rem: LOC_REMOTE_I, l_dout: LOC_DOUT_I,
                    tens: ADDR_TENS_I, units: ADDR_UNITS_I, rxd: BUS_RXD_I};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [3:0] digit(input logic [3:0] v);
        return (v > `ADDR_DIGIT_MAX) ? `ADDR_DIGIT_MAX : v;
    endfunction : digit

    function automatic fbcfg_pkg::mode_s decode_mode(input logic [3:0] m);
        fbcfg_pkg::mode_s r;
        r.proto = fbcfg_pkg::PROTO_NONE;
        r.words = 3'h0;
        unique case (m)
            4'h1, 4'h4, 4'h7, 4'hb: r.words = 3'h2;
            4'h2, 4'h5, 4'h8, 4'hc: r.words = 3'h4;
            4'h3, 4'h6, 4'h9, 4'hd: r.words = 3'h6;
            4'ha:                   r.words = `DPROF_WORDS;
            default:                r.words = 3'h0;
        endcase
        unique case (m)
            4'h1, 4'h2, 4'h3: r.proto = fbcfg_pkg::PROTO_DP;
            4'h4, 4'h5, 4'h6: r.proto = fbcfg_pkg::PROTO_DNET;
            4'h7, 4'h8, 4'h9: r.proto = fbcfg_pkg::PROTO_RTU;
            4'ha:             r.proto = fbcfg_pkg::PROTO_DPROF;
            4'hb, 4'hc, 4'hd: r.proto = fbcfg_pkg::PROTO_ETH;
            default:          r.proto = fbcfg_pkg::PROTO_NONE;
        endcase
        return r;
    endfunction : decode_mode

    always_comb begin
        logic [31:0] wv;
        logic [31:0] rv;
        logic        frst;
        logic        e129;
        logic        e130;
        logic        err;
        logic        fb_run;
        logic        remote;
        logic [3:0]  ev;
        wv     = 32'h0;
        rv     = 32'h0;
        frst   = 1'b0;
        ev     = 4'h0;
        d      = q;
        d.s1   = pins;
        d.s2   = q.s1;
        e129   = q.s2.conn;
        e130   = q.s2.board;
        err    = (q.mode != 4'h0) && (e129 || e130);
        fb_run = q.src[0] && q.src[4] && q.src[7];
        remote = (q.src[0] ? q.s2.n_rem : q.s2.l_rem) && !q.force_loc;
        d.err_prev = {e129, e130};

        // write channel: address and data taken in either order
        if (AXI_AWVALID_I && q.awrdy) begin
            d.aw_h   = 1'b1;
            d.awaddr = AXI_AWADDR_I;
        end
        if (AXI_WVALID_I && q.wrdy) begin
            d.w_h   = 1'b1;
            d.wdata = AXI_WDATA_I;
            d.wstrb = AXI_WSTRB_I;
        end
        if (q.bvalid && AXI_BREADY_I) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_h && q.w_h && !q.bvalid) begin
            d.aw_h   = 1'b0;
            d.w_h    = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = 2'h0;
            unique case (q.awaddr >> 2)
                `CFG_OFS >> 2: begin
                    wv = merge({24'h0, q.act, q.mode}, q.wdata, q.wstrb);
                    // out-of-range selector values are ignored
                    if (wv[`CFG_MODE_LSB +: 4] <= `SEL_MAX) begin
                        d.mode = wv[`CFG_MODE_LSB +: 4];
                    end
                    if (wv[`CFG_ACT_LSB +: 4] <= `SEL_MAX) begin
                        d.act = wv[`CFG_ACT_LSB +: 4];
                    end
                end
                `SRC_OFS >> 2: begin
                    wv    = merge({23'h0, q.src}, q.wdata, q.wstrb);
                    d.src = wv[8:0];
                end
                `OUTFN_OFS >> 2: begin
                    wv      = merge({25'h0, q.outfn}, q.wdata, q.wstrb);
                    d.outfn = wv[6:0];
                end
                `IRQ_STAT_OFS >> 2: begin
                    if (q.wstrb[0]) begin
                        d.irq_st = q.irq_st & ~q.wdata[3:0];
                    end
                end
                `IRQ_MASK_OFS >> 2: begin
                    wv         = merge({28'h0, q.irq_mask}, q.wdata, q.wstrb);
                    d.irq_mask = wv[3:0];
                end
                `CMD_OFS >> 2: frst = q.wstrb[0] & q.wdata[0];
                `STATUS_OFS >> 2: d.bresp = 2'h0;
                default: d.bresp = 2'h2;
            endcase
        end
        d.awrdy = !d.aw_h;
        d.wrdy  = !d.w_h;

        // read channel
        if (q.rvalid && AXI_RREADY_I) begin
            d.rvalid = 1'b0;
        end
        if (AXI_ARVALID_I && q.arrdy) begin
            d.rvalid = 1'b1;
            d.rresp  = 2'h0;
            unique case (AXI_ARADDR_I >> 2)
                `CFG_OFS >> 2:      rv = {24'h0, q.act, q.mode};
                `SRC_OFS >> 2:      rv = {23'h0, q.src};
                `OUTFN_OFS >> 2:    rv = {25'h0, q.outfn};
                `STATUS_OFS >> 2:   rv = {q.last_err, 3'h0, bdl.locked, bdl.rate_idx,
                                          1'b0, q.node, 1'b0, q.sup, q.force_loc,
                                          q.gen_dis, q.ramp, q.sup == fbcfg_pkg::SUP_FAULT,
                                          q.comm_err};
                `IRQ_STAT_OFS >> 2: rv = {28'h0, q.irq_st};
                `IRQ_MASK_OFS >> 2: rv = {28'h0, q.irq_mask};
                `CMD_OFS >> 2:      rv = 32'h0;
                default: begin
                    rv      = 32'h0;
                    d.rresp = 2'h2;
                end
            endcase
            d.rdata = rv;
        end
        d.arrdy = !d.rvalid;

        // supervision
        d.comm_err = err;
        if (e129 && !q.err_prev[1]) begin
            d.last_err = `ERR_CONN_CODE;
            ev[0]      = 1'b1;
        end
        if (e130 && !q.err_prev[0]) begin
            d.last_err = `ERR_BOARD_CODE;
            ev[1]      = 1'b1;
        end
        unique case (q.sup)
            fbcfg_pkg::SUP_OK: begin
                // action taken on entry only, never again while the error stands
                if (err) begin
                    ev[2] = 1'b1;
                    d.sup = fbcfg_pkg::SUP_ERR;
                    if (q.act == `ACT_RAMP && fb_run) begin
                        d.ramp = 1'b1;
                    end
                    if (q.act == `ACT_COAST) begin
                        d.gen_dis = 1'b1;
                    end
                    if (q.act == `ACT_LOCAL && fb_run && q.remote) begin
                        d.force_loc = 1'b1;
                    end
                    if (q.act == `ACT_FAULT) begin
                        d.sup = fbcfg_pkg::SUP_FAULT;
                        ev[3] = 1'b1;
                    end
                end
            end
            fbcfg_pkg::SUP_ERR: begin
                if (!err) begin
                    d.sup       = fbcfg_pkg::SUP_OK;
                    d.ramp      = 1'b0;
                    d.gen_dis   = 1'b0;
                    d.force_loc = 1'b0;
                end
            end
            fbcfg_pkg::SUP_FAULT: begin
                // a reset under a standing error does not fire the action again
                if (frst) begin
                    d.sup = err ? fbcfg_pkg::SUP_ERR : fbcfg_pkg::SUP_OK;
                end
            end
            default: d.sup = fbcfg_pkg::SUP_OK;
        endcase
        d.irq_st = d.irq_st | ev;
        d.irq    = |(d.irq_st & d.irq_mask);

        // command routing
        d.remote  = remote;
        d.spd_net = remote ? q.src[2] : q.src[1];
        d.run     = (remote ? (q.src[7] ? q.s2.n_run : q.s2.l_run)
                            : (q.src[4] ? q.s2.n_run : q.s2.l_run))
                    && !q.ramp && q.sup != fbcfg_pkg::SUP_FAULT;
        d.dir     = remote ? (q.src[6] ? q.s2.n_dir : q.s2.l_dir)
                           : (q.src[3] ? q.s2.n_dir : q.s2.l_dir);
        d.jog     = remote ? (q.src[8] ? q.s2.n_jog : q.s2.l_jog)
                           : (q.src[5] ? q.s2.n_jog : q.s2.l_jog);
        d.dout    = (q.outfn & q.s2.n_dout) | (~q.outfn & q.s2.l_dout);

        d.node = 7'(digit(q.s2.tens) * 4'ha) + {3'h0, digit(q.s2.units)};
        d.mdec       = decode_mode(q.mode);
        d.bd_restart = (q.mode == 4'h0) || e130;
        d.fault      = d.sup == fbcfg_pkg::SUP_FAULT;
        d.gen_en     = !d.gen_dis && !d.fault;
        d.card_en    = d.mode != 4'h0;
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q          <= '0;
            q.mode     <= `MODE_RST;
            q.act      <= `ACT_RST;
            q.gen_en   <= 1'b1;
            q.bd_restart <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bdl.rxd     = q.s2.rxd;
    assign bdl.restart = q.bd_restart;

    fieldbus_baud_detect u_baud (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (NRST_I),
        .bd      (bdl)
    );

    assign AXI_AWREADY_O = q.awrdy;
    assign AXI_WREADY_O  = q.wrdy;
    assign AXI_BVALID_O  = q.bvalid;
    assign AXI_BRESP_O   = q.bresp;
    assign AXI_ARREADY_O = q.arrdy;
    assign AXI_RVALID_O  = q.rvalid;
    assign AXI_RDATA_O   = q.rdata;
    assign AXI_RRESP_O   = q.rresp;
    assign RUN_O         = q.run;
    assign DIR_O         = q.dir;
    assign JOG_O         = q.jog;
    assign REMOTE_O      = q.remote;
    assign SPD_REF_NET_O = q.spd_net;
    assign DOUT_O        = q.dout;
    assign GEN_ENABLE_O  = q.gen_en;
    assign RAMP_STOP_O   = q.ramp;
    assign FAULT_O       = q.fault;
    assign COMM_ERR_O    = q.comm_err;
    assign CARD_ENABLE_O = q.card_en;
    assign PROTOCOL_O    = q.mdec.proto;
    assign IO_WORDS_O    = q.mdec.words;
    assign NODE_ADDR_O   = q.node;
    assign BAUD_IDX_O    = bdl.rate_idx;
    assign IRQ_O         = q.irq;
endmodule : fieldbus_config_fail_action

/* File: hw/fbcfg_cfg.svh */
// register map, reset values and timing counts of the fieldbus supervision block
`ifndef FBCFG_CFG_SVH
`define FBCFG_CFG_SVH

`define CFG_OFS        8'h00
`define SRC_OFS        8'h04
`define OUTFN_OFS      8'h08
`define STATUS_OFS     8'h0c
`define IRQ_STAT_OFS   8'h10
`define IRQ_MASK_OFS   8'h14
`define CMD_OFS        8'h18

`define CFG_MODE_LSB   0
`define CFG_ACT_LSB    4
`define MODE_RST       4'h0
`define ACT_RST        4'h0
`define SEL_MAX        4'hd

`define ACT_RAMP       4'h0
`define ACT_COAST      4'h1
`define ACT_NONE       4'h2
`define ACT_LOCAL      4'h3
`define ACT_FAULT      4'h5

`define ERR_CONN_CODE  8'h81
`define ERR_BOARD_CODE 8'h82
`define DPROF_WORDS    3'h2
`define ADDR_DIGIT_MAX 4'h9

// bit times at 10 MHz: 1042, 521, 220, 107, 53, 20, 6.7, 3.3, 1.7, 0.8 cycles
`define BD_LOCK_EDGES  5'h10
`define BD_T0          11'h2e4
`define BD_T1          11'h14a
`define BD_T2          11'h096
`define BD_T3          11'h04b
`define BD_T4          11'h023
`define BD_T5          11'h00c
`define BD_T6          11'h005
`define BD_T7          11'h003
`define BD_T8          11'h002

`endif

/* File: hw/fbcfg_pkg.sv */
// shared types of the fieldbus supervision block
package fbcfg_pkg;
    typedef enum logic [1:0] {
        SUP_OK    = 2'h0,
        SUP_ERR   = 2'h1,
        SUP_FAULT = 2'h3
    } sup_state_e;

    typedef enum logic [2:0] {
        PROTO_NONE  = 3'h0,
        PROTO_DP    = 3'h1,
        PROTO_DNET  = 3'h2,
        PROTO_RTU   = 3'h3,
        PROTO_DPROF = 3'h4,
        PROTO_ETH   = 3'h5
    } proto_e;

    typedef struct packed {
        proto_e     proto;
        logic [2:0] words;
    } mode_s;
endpackage : fbcfg_pkg

/* File: hw/fbcfg_if.sv */
// link between the supervision block and its baud rate detector
`timescale 1ns/1ns
interface fbcfg_if;
    logic       rxd;
    logic       restart;
    logic [3:0] rate_idx;
    logic       locked;

    modport ctl (output rxd, output restart, input rate_idx, input locked);
    modport det (input rxd, input restart, output rate_idx, output locked);
endinterface : fbcfg_if

/* File: hw/fieldbus_baud_detect.sv */
// baud rate detector: shortest pulse on the bus receive line
`timescale 1ns/1ns
`include "fbcfg_cfg.svh"
module fieldbus_baud_detect (
    input wire logic clk_i,
    input wire logic rst_n_i,
    fbcfg_if.det     bd
);
    typedef struct packed {
        logic        prev;
        logic [10:0] run;
        logic [10:0] min_w;
        logic [4:0]  edges;
        logic [3:0]  rate;
        logic        locked;
    } bd_s;

    bd_s q;
    bd_s d;

    // 6 and 12 Mbit/s bits are below two cycles at 10 MHz; they share the short bins
    function automatic logic [3:0] classify(input logic [10:0] w);
        if (w >= `BD_T0) return 4'h0;
        if (w >= `BD_T1) return 4'h1;
        if (w >= `BD_T2) return 4'h2;
        if (w >= `BD_T3) return 4'h3;
        if (w >= `BD_T4) return 4'h4;
        if (w >= `BD_T5) return 4'h5;
        if (w >= `BD_T6) return 4'h6;
        if (w >= `BD_T7) return 4'h7;
        if (w >= `BD_T8) return 4'h8;
        return 4'h9;
    endfunction : classify

    always_comb begin
        d = q;
        d.prev = bd.rxd;
        if (bd.restart) begin
            d.run    = 11'h001;
            d.min_w  = 11'h7ff;
            d.edges  = 5'h00;
            d.locked = 1'b0;
        end else if (bd.rxd != q.prev) begin
            // first run after restart is partial, so it is not measured
            if (q.edges != 5'h00 && q.run < q.min_w) begin
                d.min_w = q.run;
            end
            d.run = 11'h001;
            if (q.edges != 5'h1f) begin
                d.edges = q.edges + 5'h01;
            end
        end else if (q.run != 11'h7ff) begin
            d.run = q.run + 11'h001;
        end
        if (!bd.restart && q.edges >= `BD_LOCK_EDGES) begin
            d.locked = 1'b1;
            d.rate   = classify(q.min_w);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{prev: 1'b1, run: 11'h001, min_w: 11'h7ff, edges: 5'h00,
                   rate: 4'h0, locked: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign bd.rate_idx = q.rate;
    assign bd.locked   = q.locked;
endmodule : fieldbus_baud_detect

/* File: sim/net_master_model.sv */
// network master model: link state, cyclic commands and bus line activity
`timescale 1ns/1ns
module net_master_model (
    input  wire logic        clk_i,
    input  wire logic        drop_i,
    input  wire logic        card_off_i,
    input  wire logic [10:0] cmd_i,
    output logic             conn_off_o = 1'b0,
    output logic             board_off_o = 1'b0,
    output logic [10:0]      net_o = 11'h0,
    output logic             rxd_o = 1'b1
);
    logic [9:0] bit_q = 10'h0;
    // cyclic words refresh every clock, a master that never idles
    always @(posedge clk_i) begin
        conn_off_o  <= drop_i;
        board_off_o <= card_off_i;
        net_o       <= cmd_i;
        bit_q       <= (bit_q == 10'h034) ? 10'h0 : bit_q + 10'h1;
        // 53 clocks a bit: a 187.5 kbit/s line, rate index 4
        if (bit_q == 10'h034) begin
            rxd_o <= ~rxd_o;
        end
    end
endmodule : net_master_model

/* File: sim/fieldbus_config_fail_action_assertions.sv */
// port checks of failure reactions, decoding and address range
`timescale 1ns/1ns
module fieldbus_config_fail_action_assertions (
    input wire logic       CORE_CLK_I,
    input wire logic       NRST_I,
    input wire logic       AXI_BVALID_O,
    input wire logic       CONN_INACTIVE_I,
    input wire logic       BOARD_INACTIVE_I,
    input wire logic       RUN_O,
    input wire logic       GEN_ENABLE_O,
    input wire logic       RAMP_STOP_O,
    input wire logic       FAULT_O,
    input wire logic       COMM_ERR_O,
    input wire logic [2:0] PROTOCOL_O,
    input wire logic [2:0] IO_WORDS_O,
    input wire logic [6:0] NODE_ADDR_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    // two sync stages and the flag flop lie between pin and flag
    sequence s_pin_err;
        $past(CONN_INACTIVE_I || BOARD_INACTIVE_I, 3);
    endsequence
    sequence s_resp_near;
        AXI_BVALID_O || $past(AXI_BVALID_O) || $past(AXI_BVALID_O, 2);
    endsequence
    AST_ERR_CAUSE: assert property ($rose(COMM_ERR_O) |-> s_pin_err)
        else $error("error flag without link or board loss");
    AST_COAST: assert property ($fell(GEN_ENABLE_O) |-> COMM_ERR_O || FAULT_O)
        else $error("enable dropped without an error");
    AST_FAULT_OFF: assert property (FAULT_O [*2] |-> !GEN_ENABLE_O && !RUN_O)
        else $error("motor still driven in fault");
    AST_RAMP_RUN: assert property (RAMP_STOP_O [*2] |-> !RUN_O)
        else $error("run kept during ramp stop");
    AST_FAULT_REL: assert property ($fell(FAULT_O) |-> s_resp_near)
        else $error("fault left without a register write");
    AST_WORDS: assert property (IO_WORDS_O inside {3'h0, 3'h2, 3'h4, 3'h6} &&
        ((PROTOCOL_O == 3'h0) == (IO_WORDS_O == 3'h0)))
        else $error("word count not 0, 2, 4 or 6");
    AST_DPROF: assert property (PROTOCOL_O == 3'h4 |-> IO_WORDS_O == 3'h2)
        else $error("drive profile word count wrong");
    AST_ADDR: assert property (NODE_ADDR_O <= 7'h63)
        else $error("station address above 99");
endmodule : fieldbus_config_fail_action_assertions

bind fieldbus_config_fail_action fieldbus_config_fail_action_assertions chk_u (.*);

/* File: sim/fieldbus_config_fail_action_test.sv */
// self-checking bench of the fieldbus supervision block
`timescale 1ns/1ns
module fieldbus_config_fail_action_test;
    logic CORE_CLK_I = 1'b0, NRST_I = 1'b0;
    logic [7:0] AXI_AWADDR_I = 8'h0, AXI_ARADDR_I = 8'h0;
    logic [31:0] AXI_WDATA_I = 32'h0, AXI_RDATA_O;
    logic [3:0] AXI_WSTRB_I = 4'hf, ADDR_TENS_I = 4'h0, ADDR_UNITS_I = 4'h0, BAUD_IDX_O;
    logic AXI_AWVALID_I = 1'b0, AXI_WVALID_I = 1'b0, AXI_BREADY_I = 1'b0;
    logic AXI_ARVALID_I = 1'b0, AXI_RREADY_I = 1'b0, LOC_REMOTE_I = 1'b0;
    logic LOC_RUN_I = 1'b0, LOC_DIR_I = 1'b0, LOC_JOG_I = 1'b0;
    logic [6:0] LOC_DOUT_I = 7'h0, NET_DOUT_I, DOUT_O, NODE_ADDR_O, fn;
    logic CONN_INACTIVE_I, BOARD_INACTIVE_I, BUS_RXD_I, NET_RUN_I, NET_DIR_I, NET_JOG_I;
    logic NET_REMOTE_I, AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O, AXI_ARREADY_O;
    logic AXI_RVALID_O, RUN_O, DIR_O, JOG_O, REMOTE_O, SPD_REF_NET_O, GEN_ENABLE_O;
    logic RAMP_STOP_O, FAULT_O, COMM_ERR_O, CARD_ENABLE_O, IRQ_O;
    logic [1:0] AXI_BRESP_O, AXI_RRESP_O, bq[$];
    logic [2:0] PROTOCOL_O, IO_WORDS_O;
    logic drop = 1'b0, card_off = 1'b0;
    logic [10:0] cmd = 11'h0;
    logic [33:0] rq[$];
    int n_mismatch = 0, n_checks = 0, e, k, a;
    int acts[6] = '{0, 1, 2, 3, 5, 0};

    fieldbus_config_fail_action dut_u (.*);
    net_master_model master_u (
        .clk_i       (CORE_CLK_I),
        .drop_i      (drop),
        .card_off_i  (card_off),
        .cmd_i       (cmd),
        .conn_off_o  (CONN_INACTIVE_I),
        .board_off_o (BOARD_INACTIVE_I),
        .net_o       ({NET_REMOTE_I, NET_JOG_I, NET_DIR_I, NET_RUN_I, NET_DOUT_I}),
        .rxd_o       (BUS_RXD_I)
    );

    always #50 CORE_CLK_I = ~CORE_CLK_I;

    task automatic stop_test;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic cmp_bus(input logic [33:0] x, input logic [33:0] g);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %0t exp %h got %h", $time, x, g);
        end
    endtask : cmp_bus

    task automatic cmp_pin(input logic [7:0] x, input logic [7:0] g);
        cmp_bus({26'h0, x}, {26'h0, g});
    endtask : cmp_pin

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bq.push_back(2'h0);
        AXI_AWADDR_I <= ad;
        AXI_WDATA_I <= d;
        AXI_AWVALID_I <= 1'b1;
        AXI_WVALID_I <= 1'b1;
        AXI_BREADY_I <= 1'b1;
        do begin
            @(posedge CORE_CLK_I);
            if (AXI_AWREADY_O) AXI_AWVALID_I <= 1'b0;
            if (AXI_WREADY_O) AXI_WVALID_I <= 1'b0;
            #1;
        end while (AXI_AWVALID_I || AXI_WVALID_I);
        do @(posedge CORE_CLK_I); while (!AXI_BVALID_O);
        AXI_BREADY_I <= 1'b0;
        @(posedge CORE_CLK_I);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [33:0] x);
        rq.push_back(x);
        AXI_ARADDR_I <= ad;
        AXI_ARVALID_I <= 1'b1;
        AXI_RREADY_I <= 1'b1;
        do @(posedge CORE_CLK_I); while (!AXI_ARREADY_O);
        AXI_ARVALID_I <= 1'b0;
        do @(posedge CORE_CLK_I); while (!AXI_RVALID_O);
        AXI_RREADY_I <= 1'b0;
        @(posedge CORE_CLK_I);
    endtask : rd

    // results are taken at the handshake edge, before that edge's updates land
    always @(posedge CORE_CLK_I) begin
        if (AXI_RVALID_O && AXI_RREADY_I) cmp_bus(rq.pop_front(), {AXI_RRESP_O, AXI_RDATA_O});
        if (AXI_BVALID_O && AXI_BREADY_I) cmp_bus({32'h0, bq.pop_front()}, {32'h0, AXI_BRESP_O});
    end

    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h5702aca8));
        repeat (12) @(posedge CORE_CLK_I);
        NRST_I <= 1'b1;
        @(posedge CORE_CLK_I);
        rd(8'h00, 34'h0);
        rd(8'h1c, {2'h2, 32'h0});
        for (int m = 0; m < 15; m++) begin
            e = (m == 14) ? 13 : m;
            k = (e > 10) ? e - 11 : e - 1;
            wr(8'h00, 32'(m));
            repeat (2) @(posedge CORE_CLK_I);
            cmp_pin(8'(e == 0 ? 0 : e < 4 ? 1 : e < 7 ? 2 : e < 10 ? 3 : e == 10 ? 4 : 5),
                8'(PROTOCOL_O));
            cmp_pin(8'(e == 0 ? 0 : e == 10 ? 2 : (k % 3 + 1) * 2), 8'(IO_WORDS_O));
            cmp_pin(8'(e != 0), 8'(CARD_ENABLE_O));
        end
        rd(8'h00, 34'hd);
        repeat (6) begin
            fn = 7'($urandom);
            wr(8'h08, {25'h0, fn});
            ADDR_TENS_I <= 4'($urandom_range(9));
            ADDR_UNITS_I <= 4'($urandom_range(9));
            LOC_DOUT_I <= 7'($urandom);
            LOC_REMOTE_I <= 1'($urandom);
            cmd <= 11'($urandom);
            repeat (6) @(posedge CORE_CLK_I);
            cmp_pin(8'(ADDR_TENS_I) * 8'ha + 8'(ADDR_UNITS_I), 8'(NODE_ADDR_O));
            cmp_pin(8'(cmd[6:0] & fn | LOC_DOUT_I & ~fn), 8'(DOUT_O));
        end
        for (int i = 0; i < 6; i++) begin
            a = acts[i];
            wr(8'h04, (i == 5) ? 32'h0 : 32'h1ff);
            wr(8'h00, 32'(a * 16 + 1));
            wr(8'h14, (a == 2) ? 32'h0 : 32'hf);
            cmd <= 11'h780;
            repeat (6) @(posedge CORE_CLK_I);
            drop <= i[0];
            card_off <= ~i[0];
            repeat (8) @(posedge CORE_CLK_I);
            cmp_pin(8'h1, 8'(COMM_ERR_O));
            cmp_pin(8'(a == 0 && i < 5), 8'(RAMP_STOP_O));
            cmp_pin(8'(a != 1 && a != 5), 8'(GEN_ENABLE_O));
            cmp_pin(8'(i == 5 ? LOC_REMOTE_I : a != 3), 8'(REMOTE_O));
            cmp_pin(8'({i > 0 && i < 4, {3{i < 5}}}),
                8'({RUN_O, DIR_O, JOG_O, SPD_REF_NET_O}));
            cmp_pin(8'(a == 5), 8'(FAULT_O));
            cmp_pin(8'(a != 2), 8'(IRQ_O));
            wr(8'h10, 32'hf);
            drop <= 1'b0;
            card_off <= 1'b0;
            repeat (8) @(posedge CORE_CLK_I);
            cmp_pin(8'(a == 5), 8'(FAULT_O));
            cmp_pin(8'h0, 8'(IRQ_O));
            wr(8'h18, 32'h1);
            repeat (4) @(posedge CORE_CLK_I);
            cmp_pin(8'h0, 8'(FAULT_O));
        end
        repeat (1000) @(posedge CORE_CLK_I);
        cmp_pin(8'h4, 8'(BAUD_IDX_O));
        stop_test();
    end
endmodule : fieldbus_config_fail_action_test
